// >>> design/adrs_consts.vh
// Register offsets, field positions, codes and timing constants for the diversity receive sequencer
`ifndef ADRS_CONSTS_VH
`define ADRS_CONSTS_VH

`define ADRS_ADDR_W 11
`define ADRS_OFS_RX_STOP 11'h001
`define ADRS_OFS_RX_ENTER 11'h00c
`define ADRS_OFS_TMR_LO 11'h02c
`define ADRS_OFS_TMR_HI 11'h02d
`define ADRS_OFS_TMR_CTL 11'h034
`define ADRS_OFS_IRQ_FLAGS 11'h038
`define ADRS_OFS_IRQ_EN 11'h03b
`define ADRS_OFS_COR_STAT 11'h408
`define ADRS_OFS_IRQ_CFG_A 11'h4e2
`define ADRS_OFS_IRQ_CFG_B 11'h4e3
`define ADRS_OFS_DET_STATE 11'h4fa
`define ADRS_OFS_ANT_SEL 11'h4fb

// Bit positions
`define ADRS_BIT_MODEM 7
`define ADRS_BIT_TMR 6
`define ADRS_BIT_START 0

// Reset values
`define ADRS_RST_BYTE 8'h00

// Detection state codes
`define ADRS_DET_IDLE 8'h00
`define ADRS_DET_SEARCH 8'h01
`define ADRS_DET_PRE_A 8'h03
`define ADRS_DET_PRE_B 8'h04
`define ADRS_DET_SFD 8'h05

// Modem interrupt source codes
`define ADRS_CFGB_LEVEL 8'h88
`define ADRS_CFGB_TIMER 8'h22

// Timer tick: one wait unit in ns, cycles per unit at a 40 ns clock
`define ADRS_TICK_NS 40
`define ADRS_CLK_NS 40
`define ADRS_TICK_CYC ((`ADRS_TICK_NS + `ADRS_CLK_NS - 1) / `ADRS_CLK_NS)

`endif

// >>> design/adrs_ant_pick.v
// Antenna comparator: picks the input with the stronger signal during preamble search
`timescale 1ns/10ps
module adrs_ant_pick #(
    parameter RSSI_W = 8
) (
    input wire clk,
    input wire sys_rst,
    input wire enable,
    input wire [RSSI_W-1:0] rssiA,
    input wire [RSSI_W-1:0] rssiB,
    output reg antSel
);
    // One extra bit so the hysteresis sum never wraps at full scale
    wire [RSSI_W:0] rssiAUp = {1'b0, rssiA} + {{RSSI_W{1'b0}}, 1'b1};
    wire [RSSI_W:0] rssiBUp = {1'b0, rssiB} + {{RSSI_W{1'b0}}, 1'b1};

    // RSSI words come from the front end in this clock domain; small hysteresis avoids chatter
    always @(posedge clk) begin
        if (sys_rst) begin
            antSel <= 1'b0;
        end else if (enable) begin
            if ({1'b0, rssiB} > rssiAUp) begin
                antSel <= 1'b1;
            end else if ({1'b0, rssiA} > rssiBUp) begin
                antSel <= 1'b0;
            end
        end
    end
endmodule

// >>> design/adrs_seq.v
// Diversity receive sequencer: register file, detection state, MAC timer and antenna selection
//
// Notes on behaviour
// - Reading the status register at 0x408 clears its pending status.
// - Detection state reads 5 once a start-of-frame delimiter is found.
// - Detection state reads 3 or 4 once a preamble is found.
// - After preamble, bit 7 of 0x03b enables the no-delimiter interrupt.
// - Device switches antennas and keeps the one with the stronger signal.
//
// Register map (byte wide, 11-bit offsets)
//   0x001 receive stop control; bit 0 set drops back to idle
//   0x00c receive enter control; bit 0 set starts the preamble search
//   0x02c timer wait, low byte
//   0x02d timer wait, high byte
//   0x034 timer control; bit 0 starts the count and clears itself when done
//   0x038 interrupt flags, read only; bit 7 modem event, bit 6 timer done
//   0x03b interrupt enable; bit 7 gates the modem flag
//   0x408 sticky status, read only, cleared by any read
//   0x4e2 modem interrupt setting A, stored only
//   0x4e3 modem interrupt setting B; picks the modem event source
//   0x4fa detection state, read only
//   0x4fb selected antenna in bit 0, read only
//
// Detection state codes
//   0 idle, 1 searching, 3 preamble just found, 4 preamble held,
//   5 start-of-frame found; held until a stop write
//
// Modem event sources selected by 0x4e3
//   0x22 timer done, 0x88 preamble edge, anything else the no-delimiter timeout
//
// Limitations
//   The timer wait is latched at the start write; later writes to 0x02c or
//   0x02d only apply to the next start.
//   A stop write wins over every pin event in the same cycle.
//   Unmapped offsets read zero and ignore writes, so a typo in host code is silent.
//   Read data is zero outside the cycle after a read strobe, to keep bus merging safe.
//   Pin events pass a two-stage synchroniser and reach the state four cycles later.
//   The antenna choice only moves while searching, so a found preamble is not disturbed.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "adrs_consts.vh"
module adrs_seq #(
    parameter RSSI_W = 8,
    parameter SFD_TIMEOUT = 16'd4000
) (
    input wire clk,
    input wire sys_rst,
    input wire [`ADRS_ADDR_W-1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    input wire preambleIn,
    input wire sfdIn,
    input wire [RSSI_W-1:0] rssiA,
    input wire [RSSI_W-1:0] rssiB,
    output wire rxActive,
    output wire antSel
);
    // Receive states, one-hot
    localparam ST_IDLE = 4'b0001;
    localparam ST_SRCH = 4'b0010;
    localparam ST_PRE = 4'b0100;
    localparam ST_SFD = 4'b1000;

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers: first stage feeds only the second
    reg [1:0] preS1Q, preS2Q;
    reg [1:0] sfdS1Q, sfdS2Q;
    wire preSeen;
    wire sfdSeen;

    always @(posedge clk) begin
        if (sys_rst) begin
            preS1Q <= 2'h0;
            preS2Q <= 2'h0;
            sfdS1Q <= 2'h0;
            sfdS2Q <= 2'h0;
        end else begin
            preS1Q <= {preS1Q[0], preambleIn};
            preS2Q <= {preS2Q[0], preS1Q[1]};
            sfdS1Q <= {sfdS1Q[0], sfdIn};
            sfdS2Q <= {sfdS2Q[0], sfdS1Q[1]};
        end
    end
    // Second stage pairs give synchronised level and previous level
    assign preSeen = preS2Q[0] & ~preS2Q[1];
    assign sfdSeen = sfdS2Q[0] & ~sfdS2Q[1];

    ////////////////////////////////////////////////////////////////////////
    // Address decode helper, used for both strobes
    function hit;
        input [`ADRS_ADDR_W-1:0] a;
        input [`ADRS_ADDR_W-1:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    wire wrStop = regWr & hit(regAddr, `ADRS_OFS_RX_STOP);
    wire wrEnter = regWr & hit(regAddr, `ADRS_OFS_RX_ENTER);
    wire wrTmrCtl = regWr & hit(regAddr, `ADRS_OFS_TMR_CTL);
    wire rdStat = regRd & hit(regAddr, `ADRS_OFS_COR_STAT);

    ////////////////////////////////////////////////////////////////////////
    // Plain read/write registers
    reg [7:0] stopCtlQ, enterCtlQ, tmrLoQ, tmrHiQ, tmrCtlQ, irqEnQ, cfgAQ, cfgBQ;

    always @(posedge clk) begin
        if (sys_rst) begin
            stopCtlQ <= `ADRS_RST_BYTE;
            enterCtlQ <= `ADRS_RST_BYTE;
            tmrLoQ <= `ADRS_RST_BYTE;
            tmrHiQ <= `ADRS_RST_BYTE;
            irqEnQ <= `ADRS_RST_BYTE;
            cfgAQ <= `ADRS_RST_BYTE;
            cfgBQ <= `ADRS_RST_BYTE;
        end else if (regWr) begin
            if (hit(regAddr, `ADRS_OFS_RX_STOP)) stopCtlQ <= regWrData;
            if (hit(regAddr, `ADRS_OFS_RX_ENTER)) enterCtlQ <= regWrData;
            if (hit(regAddr, `ADRS_OFS_TMR_LO)) tmrLoQ <= regWrData;
            if (hit(regAddr, `ADRS_OFS_TMR_HI)) tmrHiQ <= regWrData;
            if (hit(regAddr, `ADRS_OFS_IRQ_EN)) irqEnQ <= regWrData;
            if (hit(regAddr, `ADRS_OFS_IRQ_CFG_A)) cfgAQ <= regWrData;
            if (hit(regAddr, `ADRS_OFS_IRQ_CFG_B)) cfgBQ <= regWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive state machine
    reg [3:0] stQ, stD;
    reg [15:0] sfdWaitQ;
    wire sfdTimeout = (stQ == ST_PRE) && (sfdWaitQ == SFD_TIMEOUT);

    always @* begin
        stD = stQ;
        case (stQ)
            ST_IDLE: begin
                if (wrEnter && regWrData[`ADRS_BIT_START]) stD = ST_SRCH;
            end
            ST_SRCH: begin
                if (sfdSeen) stD = ST_SFD;
                else if (preSeen) stD = ST_PRE;
            end
            ST_PRE: begin
                if (sfdSeen) stD = ST_SFD;
                else if (sfdTimeout) stD = ST_SRCH;
            end
            ST_SFD: begin
                stD = ST_SFD;
            end
            default: begin
                stD = ST_IDLE;
            end
        endcase
        // Stop overrides everything, then a fresh enter restarts the search
        if (wrStop && regWrData[`ADRS_BIT_START]) stD = ST_IDLE;
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            stQ <= ST_IDLE;
            sfdWaitQ <= 16'h0000;
        end else begin
            stQ <= stD;
            if (stQ == ST_PRE && stD == ST_PRE) sfdWaitQ <= sfdWaitQ + 16'h0001;
            else sfdWaitQ <= 16'h0000;
        end
    end

    reg [7:0] detState;
    always @* begin
        case (stQ)
            ST_IDLE: detState = `ADRS_DET_IDLE;
            ST_SRCH: detState = `ADRS_DET_SEARCH;
            // Preamble code, 4 once the preamble state has been held four cycles
            ST_PRE: detState = sfdWaitQ[15:2] != 14'h0000 ? `ADRS_DET_PRE_B : `ADRS_DET_PRE_A;
            ST_SFD: detState = `ADRS_DET_SFD;
            default: detState = `ADRS_DET_IDLE;
        endcase
    end
    assign rxActive = (stQ != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // MAC timer: loaded from the wait registers, counts ticks once started
    reg [15:0] tmrCntQ;
    reg tmrRunQ;
    reg [7:0] tickQ;
    wire tick = (tickQ == (`ADRS_TICK_CYC - 1));
    wire tmrDone = tmrRunQ && tick && (tmrCntQ == 16'h0000);

    always @(posedge clk) begin
        if (sys_rst) begin
            tmrCntQ <= 16'h0000;
            tmrRunQ <= 1'b0;
            tickQ <= 8'h00;
            tmrCtlQ <= `ADRS_RST_BYTE;
        end else begin
            tickQ <= (tick || !tmrRunQ) ? 8'h00 : tickQ + 8'h01;
            if (wrTmrCtl) begin
                tmrCtlQ <= regWrData;
                tmrRunQ <= regWrData[`ADRS_BIT_START];
                tmrCntQ <= {tmrHiQ, tmrLoQ};
            end else if (tmrDone) begin
                tmrRunQ <= 1'b0;
                tmrCtlQ[`ADRS_BIT_START] <= 1'b0;
            end else if (tmrRunQ && tick) begin
                tmrCntQ <= tmrCntQ - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt flags: modem source chosen by config B
    // No-delimiter event while preamble is held and config B is neither the timer nor the level code
    wire modemEvent = (cfgBQ == `ADRS_CFGB_TIMER) ? tmrDone
                    : (cfgBQ == `ADRS_CFGB_LEVEL) ? preSeen
                    : sfdTimeout;
    reg [7:0] flagsQ;
    reg [7:0] statQ;

    // Modem flag sticks while enabled and clearing its enable bit drops it; timer flag sets on done, clears on a timer control write
    always @(posedge clk) begin
        if (sys_rst) begin
            flagsQ <= `ADRS_RST_BYTE;
        end else begin
            if (modemEvent && irqEnQ[`ADRS_BIT_MODEM]) flagsQ[`ADRS_BIT_MODEM] <= 1'b1;
            else if (!irqEnQ[`ADRS_BIT_MODEM]) flagsQ[`ADRS_BIT_MODEM] <= 1'b0;
            if (tmrDone) flagsQ[`ADRS_BIT_TMR] <= 1'b1;
            else if (wrTmrCtl) flagsQ[`ADRS_BIT_TMR] <= 1'b0;
        end
    end

    // Clear-on-read status; a new event in the read cycle survives
    always @(posedge clk) begin
        if (sys_rst) begin
            statQ <= `ADRS_RST_BYTE;
        end else begin
            statQ <= (rdStat ? 8'h00 : statQ)
                   | {modemEvent, tmrDone, 4'h0, sfdSeen, preSeen};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Antenna choice tracks the stronger input while searching
    wire antPick;
    adrs_ant_pick #(
        .RSSI_W(RSSI_W)
    ) uAntPick (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(stQ == ST_SRCH),
        .rssiA(rssiA),
        .rssiB(rssiB),
        .antSel(antPick)
    );
    assign antSel = antPick;

    ////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe; unmapped reads zero
    always @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                `ADRS_OFS_RX_STOP: regRdData <= stopCtlQ;
                `ADRS_OFS_RX_ENTER: regRdData <= enterCtlQ;
                `ADRS_OFS_TMR_LO: regRdData <= tmrLoQ;
                `ADRS_OFS_TMR_HI: regRdData <= tmrHiQ;
                `ADRS_OFS_TMR_CTL: regRdData <= tmrCtlQ;
                `ADRS_OFS_IRQ_FLAGS: regRdData <= flagsQ;
                `ADRS_OFS_IRQ_EN: regRdData <= irqEnQ;
                `ADRS_OFS_COR_STAT: regRdData <= statQ;
                `ADRS_OFS_IRQ_CFG_A: regRdData <= cfgAQ;
                `ADRS_OFS_IRQ_CFG_B: regRdData <= cfgBQ;
                `ADRS_OFS_DET_STATE: regRdData <= detState;
                `ADRS_OFS_ANT_SEL: regRdData <= {7'h00, antPick};
                default: regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end
endmodule

// >>> bench/adrs_seq_checker.sv
// Port checker for the diversity receive sequencer
`timescale 1ns/10ps
`include "adrs_consts.vh"
module adrs_seq_checker #(
    parameter RSSI_W = 8,
    parameter SFD_TIMEOUT = 16'd4000
) (
    input wire clk,
    input wire sys_rst,
    input wire [`ADRS_ADDR_W-1:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdData,
    input wire preambleIn,
    input wire sfdIn,
    input wire [RSSI_W-1:0] rssiA,
    input wire [RSSI_W-1:0] rssiB,
    input wire rxActive,
    input wire antSel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic enMod_q;
    ////////////////////////////////////////////////////////////
    // Shadow of the modem enable bit, so the flag can be judged without internals
    always @(posedge clk) begin
        if (sys_rst) begin
            enMod_q <= 1'b0;
        end else if (regWr && regAddr == `ADRS_OFS_IRQ_EN) begin
            enMod_q <= regWrData[`ADRS_BIT_MODEM];
        end
    end
    // Commands and reads as seen on the register port
    sequence enterCmd;
        regWr && regAddr == `ADRS_OFS_RX_ENTER && regWrData[0];
    endsequence
    sequence stopCmd;
        regWr && regAddr == `ADRS_OFS_RX_STOP && regWrData[0];
    endsequence
    sequence stateRead;
        regRd && regAddr == `ADRS_OFS_DET_STATE;
    endsequence
    rx_enter_a: assert property (enterCmd |=> rxActive) else $error("receive entry missed");
    rx_stop_a: assert property (stopCmd |=> !rxActive) else $error("receive stop missed");
    rd_window_a: assert property (!regRd |=> regRdData == 8'h00) else $error("read data outside window");
    det_code_a: assert property (stateRead |=> regRdData inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h05})
        else $error("bad detection code");
    det_idle_a: assert property (stateRead and !rxActive |=> regRdData == `ADRS_DET_IDLE)
        else $error("idle state not zero");
    det_live_a: assert property (stateRead and rxActive |=> regRdData != 8'h00)
        else $error("active state reads zero");
    ant_hold_a: assert property (!rxActive |=> $stable(antSel)) else $error("antenna moved while idle");
    flag_mask_a: assert property (regRd && regAddr == `ADRS_OFS_IRQ_FLAGS && !enMod_q && !$past(enMod_q)
        |=> !regRdData[`ADRS_BIT_MODEM]) else $error("modem flag while inhibited");
endmodule

// >>> bench/adrs_host_model.sv
// Host controller model driving the register port
`timescale 1ns/10ps
`include "adrs_consts.vh"
module adrs_host_model (
    input wire clk,
    input wire [7:0] regRdData,
    output logic [10:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWr,
    output logic regRd
);
    logic [10:0] initA [15] = '{11'h00e, 11'h0b2, 11'h0ce, 11'h0d1, 11'h0d0, 11'h42d, 11'h408, 11'h4e3,
        11'h4e4, 11'h4e7, 11'h4e8, 11'h4f4, 11'h4f9, 11'h4fc, 11'h513};
    logic [7:0] initD [15] = '{8'h98, 8'h07, 8'h07, 8'hff, 8'hff, 8'h06, 8'h00, 8'h88,
        8'h88, 8'h98, 8'h01, 8'h06, 8'h03, 8'h01, 8'h0e};
    ////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        regAddr = 11'h000;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // Released write data is inverted so stale values never look valid
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        regWrData <= ~d;
        #1;
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic setBits(input logic [10:0] a, input logic [7:0] orM, input logic [7:0] andM);
        logic [7:0] v;
        rd(a, v);
        wr(a, (v & andM) | orM);
    endtask
    // base setup assumed done; diversity values in order
    task automatic initSeq();
        logic [7:0] v;
        foreach (initA[i])
            if (initA[i] == `ADRS_OFS_COR_STAT) rd(initA[i], v);
            else wr(initA[i], initD[i]);
    endtask
    // timer wait, source change, dummy read, start
    task automatic timerSeq();
        logic [7:0] v;
        wr(`ADRS_OFS_TMR_LO, 8'hff);
        wr(`ADRS_OFS_TMR_HI, 8'h4a);
        wr(`ADRS_OFS_IRQ_CFG_B, `ADRS_CFGB_TIMER);
        rd(`ADRS_OFS_COR_STAT, v);
        setBits(`ADRS_OFS_TMR_CTL, 8'h01, 8'hff);
    endtask
    task automatic afterPre();
        wr(`ADRS_OFS_IRQ_CFG_B, 8'h94);
        wr(`ADRS_OFS_IRQ_CFG_A, 8'h06);
    endtask
    task automatic retry();
        wr(`ADRS_OFS_RX_STOP, 8'h01);
        wr(`ADRS_OFS_IRQ_CFG_A, 8'h00);
        wr(`ADRS_OFS_IRQ_CFG_B, `ADRS_CFGB_LEVEL);
        setBits(`ADRS_OFS_RX_ENTER, 8'h01, 8'hff);
    endtask
endmodule

// >>> bench/tb.sv
// Self-checking bench for the diversity receive sequencer
`timescale 1ns/10ps
`include "adrs_consts.vh"
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic preambleIn = 1'b0;
    logic sfdIn = 1'b0;
    logic [7:0] rssiA = 8'h00;
    logic [7:0] rssiB = 8'h00;
    logic [10:0] regAddr;
    logic [7:0] regWrData, regRdData, d;
    logic regWr, regRd, rxActive, antSel;
    logic [31:0] seed = 32'hf6ed;
    int errorCnt = 0;
    int comparisons = 0;
    int cyc = 0;
    int n0;
    int shadow [logic [10:0]];
    logic [10:0] rwOfs [9] = '{11'h001, 11'h00c, 11'h02c, 11'h02d, 11'h034, 11'h03b, 11'h4e2, 11'h4e3, 11'h7ff};
    logic [10:0] roOfs [4] = '{11'h038, 11'h408, 11'h4fa, 11'h7ff};
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    adrs_seq #(.SFD_TIMEOUT(16'd40)) dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .preambleIn(preambleIn),
        .sfdIn(sfdIn), .rssiA(rssiA), .rssiB(rssiB), .rxActive(rxActive), .antSel(antSel));
    adrs_host_model host (.clk(clk), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] nextRnd(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic checkPin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("Error at %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [10:0] a, input logic [7:0] exp, input logic [7:0] msk);
        logic [7:0] v;
        host.rd(a, v);
        comparisons++;
        if ((v & msk) !== (exp & msk)) begin
            errorCnt++;
            $display("Error at %0t: reg %h read %h expected %h", $time, a, v, exp);
        end
    endtask
    task automatic finishTest();
        if (errorCnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard well beyond the long timer run
    initial begin
        repeat (40000) @(posedge clk);
        errorCnt++;
        finishTest();
    end
    // Main sequence; unmapped 0x7ff stays zero in the shadow model
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (rwOfs[i]) begin
            rdChk(rwOfs[i], 8'h00, 8'hff);
            seed = nextRnd(seed);
            shadow[rwOfs[i]] = (rwOfs[i] == 11'h7ff) ? 0 : seed[7:0] & 8'hfe;
            host.wr(rwOfs[i], seed[7:0] & 8'hfe);
            rdChk(rwOfs[i], shadow[rwOfs[i]], 8'hfe);
        end
        host.wr(`ADRS_OFS_DET_STATE, 8'h05);
        foreach (roOfs[i]) rdChk(roOfs[i], 8'h00, 8'hff);
        host.initSeq();
        host.setBits(`ADRS_OFS_IRQ_EN, 8'h80, 8'hff);
        host.wr(`ADRS_OFS_RX_ENTER, 8'h01);
        checkPin(rxActive, 1'b1);
        rdChk(`ADRS_OFS_DET_STATE, `ADRS_DET_SEARCH, 8'hff);
        for (int k = 0; k < 2; k++) begin
            seed = nextRnd(seed);
            @(posedge clk);
            rssiA <= k ? seed[7:0] | 8'h80 : seed[7:0] & 8'h3f;
            rssiB <= k ? seed[7:0] & 8'h3f : seed[7:0] | 8'h80;
            repeat (4) @(posedge clk);
            #1 checkPin(antSel, k == 0);
            rdChk(`ADRS_OFS_ANT_SEL, {7'h00, (k == 0)}, 8'hff);
        end
        @(posedge clk);
        preambleIn <= 1'b1;
        d = 8'h00;
        for (int n = 0; n < 20 && !d[7]; n++) host.rd(`ADRS_OFS_IRQ_FLAGS, d);
        checkPin(d[7], 1'b1);
        host.setBits(`ADRS_OFS_IRQ_EN, 8'h00, 8'h7f);
        rdChk(`ADRS_OFS_IRQ_FLAGS, 8'h00, 8'h80);
        host.afterPre();
        rdChk(`ADRS_OFS_DET_STATE, `ADRS_DET_PRE_B, 8'hff);
        host.setBits(`ADRS_OFS_IRQ_EN, 8'h80, 8'hff);
        repeat (40) @(posedge clk);
        rdChk(`ADRS_OFS_DET_STATE, `ADRS_DET_SEARCH, 8'hff);
        rdChk(`ADRS_OFS_IRQ_FLAGS, 8'h80, 8'h80);
        @(posedge clk);
        preambleIn <= 1'b0;
        host.retry();
        checkPin(rxActive, 1'b1);
        host.setBits(`ADRS_OFS_IRQ_EN, 8'h00, 8'h7f);
        host.timerSeq();
        n0 = cyc;
        d = 8'h01;
        while (d[0] && cyc - n0 < 20000) host.rd(`ADRS_OFS_TMR_CTL, d);
        checkPin(cyc - n0 >= 19199 && cyc - n0 <= 19206, 1'b1);
        rdChk(`ADRS_OFS_IRQ_FLAGS, 8'h40, 8'h40);
        @(posedge clk);
        preambleIn <= 1'b1;
        repeat (6) @(posedge clk);
        sfdIn <= 1'b1;
        repeat (6) @(posedge clk);
        rdChk(`ADRS_OFS_DET_STATE, `ADRS_DET_SFD, 8'hff);
        rdChk(`ADRS_OFS_COR_STAT, 8'h03, 8'h03);
        rdChk(`ADRS_OFS_COR_STAT, 8'h00, 8'h03);
        host.wr(`ADRS_OFS_RX_STOP, 8'h01);
        checkPin(rxActive, 1'b0);
        finishTest();
    end
endmodule
bind adrs_seq adrs_seq_checker #(.RSSI_W(RSSI_W), .SFD_TIMEOUT(SFD_TIMEOUT)) chk (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .preambleIn(preambleIn), .sfdIn(sfdIn), .rssiA(rssiA), .rssiB(rssiB), .rxActive(rxActive), .antSel(antSel));
